// file: inc/sime_pkg.sv
// constants, types and register map of the spi event enable and watermark block
// Functional notes
// - frame error flag raises an event only while its enable bit 12 is set.
// - activity flag raises an event only while its enable bit 11 is set.
// - transmit underrun raises an event only while enable bit 8 is set.
// - shift register empty raises events only while enable bit 7 is set.
// - receive overflow raises an event only while enable bit 6 is set.
// - receive buffer empty raises an event only while enable bit 5 is set.
// - transmit buffer empty raises an event only while enable bit 3 is set.
// - transmit buffer full raises an event only while enable bit 1 is set.
// - receive buffer full raises an event only while enable bit 0 is set.
// - receive watermark fires when enabled and level is at most the receive count.
// - transmit watermark fires when enabled and level exactly equals the transmit count.
// - six-bit receive watermark level held in bits 13 to 8 of high register.
// - six-bit transmit watermark level held in bits 5 to 0 of high register.
// - a watermark level above the queue depth never produces a match.
// - level bit 2 needs depth 8, bit 3 depth 16, bit 4 depth 32.
// - unimplemented bits of both mask registers read back as zero.
// - serial clock is bus clock divided by two times divisor plus one.
// - one data address: writes feed transmit buffer, reads come from receive.
// - six-bit receive and transmit element counts feed the watermark compare.
package sime_pkg;

    // ***********************************************
    // register map (byte addresses on apb)
    // ***********************************************
    localparam logic [7:0] SIME_OFF_EVT_EN = 8'h00;
    localparam logic [7:0] SIME_OFF_WM = 8'h04;
    localparam logic [7:0] SIME_OFF_BAUD = 8'h08;
    localparam logic [7:0] SIME_OFF_DATA = 8'h0c;
    localparam logic [7:0] SIME_OFF_STAT = 8'h10;
    localparam logic [7:0] SIME_OFF_PEND = 8'h14;

    // ***********************************************
    // field layout
    // ***********************************************
    localparam int SIME_BIT_FRAME_ERROR_FLAG = 12;
    localparam int SIME_BIT_BUSY = 11;
    localparam int SIME_BIT_TUR = 8;
    localparam int SIME_BIT_SHIFTER_EMPTY_FLAG = 7;
    localparam int SIME_BIT_ROV = 6;
    localparam int SIME_BIT_RBE = 5;
    localparam int SIME_BIT_TBE = 3;
    localparam int SIME_BIT_TBF = 1;
    localparam int SIME_BIT_RBF = 0;
    localparam int SIME_BIT_RXWM_EN = 15;
    localparam int SIME_BIT_TXWM_EN = 7;
    localparam int SIME_RXLVL_LSB = 8;
    localparam int SIME_TXLVL_LSB = 0;
    localparam int SIME_CNT_W = 6;
    localparam int SIME_REG_W = 16;
    localparam int SIME_STAT_CNT_LSB = 16;
    localparam int SIME_PEND_RXWM = 16;
    localparam int SIME_PEND_TXWM = 17;

    // implemented bits of the low enable register
    localparam logic [15:0] SIME_EVT_EN_IMPL = 16'h19eb;
    localparam logic [15:0] SIME_EVT_EN_RST = 16'h0000;
    localparam logic [15:0] SIME_WM_RST = 16'h0000;
    localparam int SIME_DEPTH_DEF = 32;
    localparam int SIME_DATA_W_DEF = 32;
    localparam int SIME_BRG_W_DEF = 16;

    // ***********************************************
    // carriers
    // ***********************************************
    typedef struct packed {
        logic frame_error_flag;
        logic activity_flag;
        logic underrun_flag;
        logic shifter_empty_flag;
        logic overflow_flag;
        logic rx_empty_flag;
        logic tx_empty_flag;
        logic tx_full_flag;
        logic rx_full_flag;
    } sime_flags_t;

    typedef struct packed {
        logic [SIME_CNT_W-1:0] rx_element_count;
        logic [SIME_CNT_W-1:0] tx_element_count;
    } sime_counts_t;

    // level bits that exist for a given queue depth
    function automatic logic [SIME_CNT_W-1:0] sime_lvl_impl(input int depth);
        logic [SIME_CNT_W-1:0] m;
        m = 6'h23;
        if (depth >= 8) begin
            m[2] = 1'b1;
        end
        if (depth >= 16) begin
            m[3] = 1'b1;
        end
        if (depth >= 32) begin
            m[4] = 1'b1;
        end
        return m;
    endfunction

endpackage

// file: rtl/sime_wm_cmp.sv
// watermark comparator: level against element count
`timescale 1ns/1ps
module sime_wm_cmp #(
    parameter int CNT_W = 6,
    parameter int DEPTH = 32,
    parameter bit GE_MODE = 1'b1
) (
    input wire logic en_in,
    input wire logic [CNT_W-1:0] level_in,
    input wire logic [CNT_W-1:0] count_in,
    output logic match_out
);
    localparam logic [CNT_W:0] DEPTH_W = (CNT_W+1)'(DEPTH);

    logic level_ok;
    logic hit;

    // levels beyond the queue depth can never match
    assign level_ok = ({1'b0, level_in} <= DEPTH_W);
    // receive side uses at-or-above, transmit side exact equality
    assign hit = GE_MODE ? (level_in <= count_in) : (level_in == count_in);
    assign match_out = en_in && level_ok && hit;
endmodule

// file: rtl/sime_top.sv
// spi event enable, watermark and serial clock divider with apb registers
`timescale 1ns/1ps
module sime_top
    import sime_pkg::*;
#(
    parameter int QUEUE_DEPTH = sime_pkg::SIME_DEPTH_DEF,
    parameter int DATA_W = sime_pkg::SIME_DATA_W_DEF,
    parameter int BRG_W = sime_pkg::SIME_BRG_W_DEF
) (
    input wire logic REF_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic CE_IN,
    // apb slave
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [3:0] PSTRB_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    // status of the rest of the unit
    input wire sime_pkg::sime_flags_t FLAGS_IN,
    input wire sime_pkg::sime_counts_t COUNTS_IN,
    input wire logic [DATA_W-1:0] RX_HOLD_IN,
    input wire logic SLAVE_SELECT_N_IN,
    // towards the shift engine and the interrupt controller
    output logic [DATA_W-1:0] TX_HOLD_OUT,
    output logic TX_WRITE_OUT,
    output logic RX_READ_OUT,
    output logic SCK_OUT,
    output logic RX_WM_OUT,
    output logic TX_WM_OUT,
    output logic IRQ_EVENT_OUT
);
    import sime_pkg::*;

    localparam logic [SIME_CNT_W-1:0] LVL_IMPL = sime_lvl_impl(QUEUE_DEPTH);
    localparam logic [15:0] WM_IMPL = {1'b1, 1'b0, LVL_IMPL, 1'b1, 1'b0, LVL_IMPL};

    // ***********************************************
    // registers
    // ***********************************************
    logic [15:0] evt_en_q;
    logic [15:0] wm_q;
    logic [BRG_W-1:0] baud_divisor_q;
    logic [BRG_W-1:0] div_cnt_q;
    logic sck_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [DATA_W-1:0] tx_hold_q;
    logic tx_write_q;
    logic rx_read_q;
    logic rx_wm_q;
    logic tx_wm_q;
    logic irq_q;

    // ***********************************************
    // apb decode
    // ***********************************************
    logic setup;
    logic done;
    logic wr_done;
    logic rd_done;
    logic addr_ok;
    logic [15:0] lane_mask;
    logic [15:0] wr_low16;

    // one wait-free access: pready is raised for the access phase only
    assign setup = PSEL_IN && !PENABLE_IN;
    assign done = PSEL_IN && PENABLE_IN && pready_q;
    assign wr_done = done && PWRITE_IN && !pslverr_q;
    assign rd_done = done && !PWRITE_IN && !pslverr_q;

    always_comb begin
        unique case (PADDR_IN)
            SIME_OFF_EVT_EN,
            SIME_OFF_WM,
            SIME_OFF_BAUD,
            SIME_OFF_DATA,
            SIME_OFF_STAT,
            SIME_OFF_PEND: begin
                addr_ok = 1'b1;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    assign lane_mask = {{8{PSTRB_IN[1]}}, {8{PSTRB_IN[0]}}};
    assign wr_low16 = PWDATA_IN[15:0] & lane_mask;

    // ***********************************************
    // enable and watermark registers
    // ***********************************************
    // read-only status and pending registers take no write at all
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            evt_en_q <= SIME_EVT_EN_RST;
        end else if (CE_IN) begin
            if (wr_done && PADDR_IN == SIME_OFF_EVT_EN) begin
                evt_en_q <= ((evt_en_q & ~lane_mask) | wr_low16) & SIME_EVT_EN_IMPL;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            wm_q <= SIME_WM_RST;
        end else if (CE_IN) begin
            if (wr_done && PADDR_IN == SIME_OFF_WM) begin
                wm_q <= ((wm_q & ~lane_mask) | wr_low16) & WM_IMPL;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            baud_divisor_q <= '0;
        end else if (CE_IN) begin
            if (wr_done && PADDR_IN == SIME_OFF_BAUD) begin
                baud_divisor_q <= PWDATA_IN[BRG_W-1:0];
            end
        end
    end

    // ***********************************************
    // shared data port
    // ***********************************************
    // same address for both buffers; reads drain receive, writes load transmit
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            tx_write_q <= 1'b0;
            rx_read_q <= 1'b0;
        end else if (CE_IN) begin
            tx_write_q <= wr_done && PADDR_IN == SIME_OFF_DATA;
            rx_read_q <= rd_done && PADDR_IN == SIME_OFF_DATA;
        end
    end

    // the word stays after the strobe so the shift engine may take it late
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            tx_hold_q <= '0;
        end else if (CE_IN) begin
            if (wr_done && PADDR_IN == SIME_OFF_DATA) begin
                tx_hold_q <= PWDATA_IN[DATA_W-1:0];
            end
        end
    end

    // ***********************************************
    // read data and answer
    // ***********************************************
    logic [31:0] rd_mux;
    logic [31:0] stat_word;
    logic [31:0] pend_word;
    logic [8:0] flag_vec;
    logic [8:0] evt_vec;

    // flags sit at their enable positions so software can mask them directly
    always_comb begin
        stat_word = '0;
        stat_word[SIME_BIT_FRAME_ERROR_FLAG] = FLAGS_IN.frame_error_flag;
        stat_word[SIME_BIT_BUSY] = FLAGS_IN.activity_flag;
        stat_word[SIME_BIT_TUR] = FLAGS_IN.underrun_flag;
        stat_word[SIME_BIT_SHIFTER_EMPTY_FLAG] = FLAGS_IN.shifter_empty_flag;
        stat_word[SIME_BIT_ROV] = FLAGS_IN.overflow_flag;
        stat_word[SIME_BIT_RBE] = FLAGS_IN.rx_empty_flag;
        stat_word[SIME_BIT_TBE] = FLAGS_IN.tx_empty_flag;
        stat_word[SIME_BIT_TBF] = FLAGS_IN.tx_full_flag;
        stat_word[SIME_BIT_RBF] = FLAGS_IN.rx_full_flag;
        stat_word[SIME_STAT_CNT_LSB +: SIME_CNT_W] = COUNTS_IN.tx_element_count;
        stat_word[SIME_STAT_CNT_LSB + SIME_CNT_W +: SIME_CNT_W] = COUNTS_IN.rx_element_count;
    end

    always_comb begin
        pend_word = '0;
        pend_word[SIME_REG_W-1:0] = stat_word[SIME_REG_W-1:0] & evt_en_q;
        pend_word[SIME_PEND_RXWM] = rx_wm_q;
        pend_word[SIME_PEND_TXWM] = tx_wm_q;
    end

    always_comb begin
        rd_mux = '0;
        unique case (PADDR_IN)
            SIME_OFF_EVT_EN: begin
                rd_mux[SIME_REG_W-1:0] = evt_en_q;
            end
            SIME_OFF_WM: begin
                rd_mux[SIME_REG_W-1:0] = wm_q;
            end
            SIME_OFF_BAUD: begin
                rd_mux[BRG_W-1:0] = baud_divisor_q;
            end
            SIME_OFF_DATA: begin
                rd_mux[DATA_W-1:0] = RX_HOLD_IN;
            end
            SIME_OFF_STAT: begin
                rd_mux = stat_word;
            end
            SIME_OFF_PEND: begin
                rd_mux = pend_word;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // data is sampled in setup so pready can stand from the first access cycle
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else if (CE_IN) begin
            pready_q <= setup;
            pslverr_q <= setup && !addr_ok;
        end
    end

    // unmapped reads return zero rather than whatever the mux last held
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            prdata_q <= '0;
        end else if (CE_IN) begin
            if (setup && !PWRITE_IN) begin
                prdata_q <= addr_ok ? rd_mux : '0;
            end
        end
    end

    // ***********************************************
    // event gating
    // ***********************************************
    // same order as the carrier struct, most significant flag first
    assign flag_vec[8] = FLAGS_IN.frame_error_flag;
    assign flag_vec[7] = FLAGS_IN.activity_flag;
    assign flag_vec[6] = FLAGS_IN.underrun_flag;
    assign flag_vec[5] = FLAGS_IN.shifter_empty_flag;
    assign flag_vec[4] = FLAGS_IN.overflow_flag;
    assign flag_vec[3] = FLAGS_IN.rx_empty_flag;
    assign flag_vec[2] = FLAGS_IN.tx_empty_flag;
    assign flag_vec[1] = FLAGS_IN.tx_full_flag;
    assign flag_vec[0] = FLAGS_IN.rx_full_flag;

    always_comb begin
        evt_vec[8] = flag_vec[8] & evt_en_q[SIME_BIT_FRAME_ERROR_FLAG];
        evt_vec[7] = flag_vec[7] & evt_en_q[SIME_BIT_BUSY];
        evt_vec[6] = flag_vec[6] & evt_en_q[SIME_BIT_TUR];
        evt_vec[5] = flag_vec[5] & evt_en_q[SIME_BIT_SHIFTER_EMPTY_FLAG];
        evt_vec[4] = flag_vec[4] & evt_en_q[SIME_BIT_ROV];
        evt_vec[3] = flag_vec[3] & evt_en_q[SIME_BIT_RBE];
        evt_vec[2] = flag_vec[2] & evt_en_q[SIME_BIT_TBE];
        evt_vec[1] = flag_vec[1] & evt_en_q[SIME_BIT_TBF];
        evt_vec[0] = flag_vec[0] & evt_en_q[SIME_BIT_RBF];
    end

    // ***********************************************
    // watermark comparators
    // ***********************************************
    logic rx_wm_hit;
    logic tx_wm_hit;

    sime_wm_cmp #(
        .CNT_W(SIME_CNT_W),
        .DEPTH(QUEUE_DEPTH),
        .GE_MODE(1'b1)
    ) u_rx_wm (
        .en_in(wm_q[SIME_BIT_RXWM_EN]),
        .level_in(wm_q[SIME_RXLVL_LSB +: SIME_CNT_W]),
        .count_in(COUNTS_IN.rx_element_count),
        .match_out(rx_wm_hit)
    );

    sime_wm_cmp #(
        .CNT_W(SIME_CNT_W),
        .DEPTH(QUEUE_DEPTH),
        .GE_MODE(1'b0)
    ) u_tx_wm (
        .en_in(wm_q[SIME_BIT_TXWM_EN]),
        .level_in(wm_q[SIME_TXLVL_LSB +: SIME_CNT_W]),
        .count_in(COUNTS_IN.tx_element_count),
        .match_out(tx_wm_hit)
    );

    // level-style request: it follows the counts, nothing is latched here
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            rx_wm_q <= 1'b0;
            tx_wm_q <= 1'b0;
        end else if (CE_IN) begin
            rx_wm_q <= rx_wm_hit;
            tx_wm_q <= tx_wm_hit;
        end
    end

    // built from the raw hits so it lines up with the watermark outputs
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            irq_q <= 1'b0;
        end else if (CE_IN) begin
            irq_q <= (|evt_vec) | rx_wm_hit | tx_wm_hit;
        end
    end

    // ***********************************************
    // serial clock divider
    // ***********************************************
    // half period is divisor plus one bus clocks, so divisor zero gives clk/2
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            div_cnt_q <= '0;
            sck_q <= 1'b0;
        end else if (CE_IN) begin
            if (div_cnt_q >= baud_divisor_q) begin
                div_cnt_q <= '0;
                sck_q <= !sck_q;
            end else begin
                div_cnt_q <= div_cnt_q + 1'b1;
            end
        end
    end

    // slave select is optional in slave operation; the event logic ignores it
    logic ss_unused;
    assign ss_unused = SLAVE_SELECT_N_IN;

    // ***********************************************
    // outputs
    // ***********************************************
    assign PRDATA_OUT = prdata_q;
    assign PREADY_OUT = pready_q;
    assign PSLVERR_OUT = pslverr_q;
    assign TX_HOLD_OUT = tx_hold_q;
    assign TX_WRITE_OUT = tx_write_q;
    assign RX_READ_OUT = rx_read_q;
    assign SCK_OUT = sck_q;
    assign RX_WM_OUT = rx_wm_q;
    assign TX_WM_OUT = tx_wm_q;
    assign IRQ_EVENT_OUT = irq_q;
endmodule

// file: tb/sime_chk.sv
// port checker of the spi event enable and watermark block
`timescale 1ns/1ps
module sime_chk
    import sime_pkg::*;
#(
    parameter int QUEUE_DEPTH = 32,
    parameter int DATA_W = 32
) (
    input wire logic REF_CLK_IN,
    input wire logic RESETN_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic PREADY_OUT,
    input wire logic PSLVERR_OUT,
    input wire sime_pkg::sime_flags_t FLAGS_IN,
    input wire sime_pkg::sime_counts_t COUNTS_IN,
    input wire logic [DATA_W-1:0] TX_HOLD_OUT,
    input wire logic TX_WRITE_OUT,
    input wire logic RX_READ_OUT,
    input wire logic SCK_OUT,
    input wire logic RX_WM_OUT,
    input wire logic TX_WM_OUT,
    input wire logic IRQ_EVENT_OUT
);
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESETN_IN);
    logic [15:0] div_q;
    logic [16:0] run_q;
    logic baud_wr;
    assign baud_wr = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == SIME_OFF_BAUD;
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN) begin
            div_q <= 16'h0000;
        end else if (baud_wr) begin
            div_q <= PWDATA_IN[15:0];
        end
    end
    // restarted on a divisor write, since a new divisor applies at once
    always_ff @(posedge REF_CLK_IN) begin
        if (!RESETN_IN || $changed(SCK_OUT) || baud_wr) begin
            run_q <= 17'h00000;
        end else begin
            run_q <= run_q + 17'h00001;
        end
    end
    chk_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held longer than one cycle");
    chk_zero_wait: assert property (PSEL_IN && !PENABLE_IN ##1 PSEL_IN && PENABLE_IN |-> PREADY_OUT)
        else $error("access cycle without ready");
    chk_tx_write: assert property (PREADY_OUT && PWRITE_IN && PADDR_IN == SIME_OFF_DATA
        |=> TX_WRITE_OUT && TX_HOLD_OUT == $past(PWDATA_IN)) else $error("data write not passed on");
    chk_rx_read: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN == SIME_OFF_DATA
        |=> RX_READ_OUT) else $error("data read not signalled");
    chk_tx_wm_valid: assert property (TX_WM_OUT
        |-> $past(COUNTS_IN.tx_element_count) <= QUEUE_DEPTH) else $error("tx match beyond depth");
    chk_irq_quiet: assert property ($past(FLAGS_IN) == '0 && !RX_WM_OUT && !TX_WM_OUT
        |-> !IRQ_EVENT_OUT) else $error("event without cause");
    chk_wm_irq: assert property (RX_WM_OUT || TX_WM_OUT |-> IRQ_EVENT_OUT)
        else $error("watermark not in event");
    chk_low_rsvd: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN == SIME_OFF_EVT_EN
        |-> (PRDATA_OUT & ~{16'h0000, SIME_EVT_EN_IMPL}) == '0) else $error("low reserved set");
    chk_high_rsvd: assert property (PREADY_OUT && !PWRITE_IN && PADDR_IN == SIME_OFF_WM
        |-> (PRDATA_OUT & 32'hffff4040) == '0) else $error("high reserved set");
    chk_unmapped_err: assert property (PREADY_OUT && PADDR_IN > SIME_OFF_PEND |-> PSLVERR_OUT)
        else $error("unmapped access without error");
    chk_sck_period: assert property (run_q <= {1'b0, div_q} + 17'h00001)
        else $error("serial clock half period too long");
    cover property (PSLVERR_OUT);
    cover property (RX_WM_OUT && TX_WM_OUT);
    cover property (IRQ_EVENT_OUT && $past(FLAGS_IN) != '0);
endmodule
bind sime_top sime_chk #(.QUEUE_DEPTH(QUEUE_DEPTH), .DATA_W(DATA_W)) i_chk (.REF_CLK_IN,
    .RESETN_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT,
    .PREADY_OUT, .PSLVERR_OUT, .FLAGS_IN, .COUNTS_IN, .TX_HOLD_OUT, .TX_WRITE_OUT,
    .RX_READ_OUT, .SCK_OUT, .RX_WM_OUT, .TX_WM_OUT, .IRQ_EVENT_OUT);

// file: tb/testbench.sv
// self-checking bench of the spi event enable and watermark block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    import sime_pkg::*;
    localparam int POS[9] = '{0, 1, 3, 5, 6, 7, 8, 11, 12};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, tx_hold, rx_hold = 32'h0, rd, r = 32'h0;
    logic pready, pslverr, tx_wr, rx_rd, sck, rx_wm, tx_wm, irq, err, ssel_n = 1'b1;
    sime_flags_t flags = '0;
    sime_counts_t counts = '0;
    logic [15:0] seed = 16'h0046;
    int n_errors = 0, compares = 0, cyc = 0, t0, d;
    logic [5:0] lr, lt, cr, ct;
    logic [1:0] en;
    logic xr, xt;
    sime_top i_dut (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .CE_IN(1'b1), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PSTRB_IN(4'hf), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .FLAGS_IN(flags), .COUNTS_IN(counts), .RX_HOLD_IN(rx_hold), .SLAVE_SELECT_N_IN(ssel_n),
        .TX_HOLD_OUT(tx_hold), .TX_WRITE_OUT(tx_wr), .RX_READ_OUT(rx_rd), .SCK_OUT(sck),
        .RX_WM_OUT(rx_wm), .TX_WM_OUT(tx_wm), .IRQ_EVENT_OUT(irq));
    always #5 clk = ~clk;
    // ***********************************************
    // helpers
    // ***********************************************
    task automatic summarize();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic rnd();
        seed = lfsr(seed);
        r = {r[15:0], seed};
    endtask
    // request held until ready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle();
        repeat (2) @(negedge clk);
    endtask
    task automatic wait_sck();
        logic s;
        int n;
        s = sck;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (sck === s && n < 100);
    endtask
    function automatic logic irq_exp(input logic [8:0] f, input logic [15:0] e);
        logic x;
        x = 1'b0;
        for (int i = 0; i < 9; i++) x |= f[i] & e[POS[i]];
        return x;
    endfunction
    // ***********************************************
    // tests
    // ***********************************************
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        apb(0, SIME_OFF_EVT_EN, 0);
        `CHK(rd, 32'h0)
        apb(0, SIME_OFF_WM, 0);
        `CHK(rd, 32'h0)
        for (int i = 0; i < 8; i++) begin
            rnd();
            apb(1, SIME_OFF_EVT_EN, r);
            apb(1, SIME_OFF_WM, ~r);
            apb(0, SIME_OFF_EVT_EN, 0);
            `CHK(rd, {16'h0, r[15:0] & SIME_EVT_EN_IMPL})
            apb(0, SIME_OFF_WM, 0);
            `CHK(rd, {16'h0, ~r[15:0] & 16'hbfbf})
        end
        $display("test registers done");
        apb(1, SIME_OFF_WM, 0);
        for (int i = 0; i < 17; i++) begin
            rnd();
            if (i < 9) r = {7'h0, 9'h1 << i, SIME_EVT_EN_IMPL ^ (16'h1 << POS[i])};
            @(posedge clk);
            flags <= r[24:16];
            ssel_n <= r[31];
            apb(1, SIME_OFF_EVT_EN, r);
            settle();
            `CHK(irq, irq_exp(r[24:16], r[15:0]))
            if (i < 9) apb(1, SIME_OFF_EVT_EN, 16'h1 << POS[i]);
            settle();
            xr = (i < 9) ? 1'b1 : irq_exp(r[24:16], r[15:0]);
            `CHK(irq, xr)
        end
        $display("test events done");
        for (int i = 0; i < 14; i++) begin
            rnd();
            case (i)
                0: r[25:0] = {2'h3, 6'h20, 6'h20, 6'h20, 6'h20};
                1: r[25:0] = {2'h3, 6'h21, 6'h3f, 6'h21, 6'h21};
                2: r[25:0] = {2'h3, 6'h06, 6'h09, 6'h05, 6'h0a};
                3: r[25:0] = {2'h0, 6'h00, 6'h00, 6'h00, 6'h00};
                default: ;
            endcase
            {en, ct, cr, lt, lr} = r[25:0];
            @(posedge clk);
            flags <= '0;
            counts <= {cr, ct};
            apb(1, SIME_OFF_WM, {16'h0, en[1], 1'b0, lr, en[0], 1'b0, lt});
            settle();
            xr = en[1] && lr <= cr && lr <= SIME_DEPTH_DEF;
            xt = en[0] && lt == ct && lt <= SIME_DEPTH_DEF;
            `CHK(rx_wm, xr)
            `CHK(tx_wm, xt)
            `CHK(irq, xr | xt)
            apb(0, SIME_OFF_STAT, 0);
            `CHK(rd, {4'h0, cr, ct, 16'h0})
            apb(0, SIME_OFF_PEND, 0);
            `CHK(rd, {14'h0, xt, xr, 16'h0})
        end
        $display("test watermarks done");
        rnd();
        apb(1, SIME_OFF_DATA, r);
        @(negedge clk);
        `CHK({tx_wr, tx_hold}, {1'b1, r})
        rnd();
        @(posedge clk);
        rx_hold <= r;
        apb(0, SIME_OFF_DATA, 0);
        @(negedge clk);
        `CHK({rx_rd, rd}, {1'b1, r})
        apb(1, 8'h18, r);
        `CHK(err, 1'b1)
        apb(0, 8'h18, 0);
        `CHK({err, rd}, {1'b1, 32'h0})
        $display("test data port done");
        for (int i = 0; i < 4; i++) begin
            rnd();
            d = (i == 0) ? 0 : int'(r[2:0]);
            apb(1, SIME_OFF_BAUD, d);
            repeat (20) @(negedge clk);
            wait_sck();
            t0 = cyc;
            wait_sck();
            `CHK(cyc - t0, d + 1)
        end
        $display("test serial clock done");
        summarize();
    end
endmodule
